/* File: hw/agoc_correct.sv */
// Offset subtraction, gain scaling and saturation stage
`timescale 1ns/1ps
`default_nettype none
module agoc_correct #(
  parameter int DATA_W = 24,
  parameter int GAIN_FRAC = 22
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Input word
  input wire logic in_valid,
  input wire logic signed [DATA_W-1:0] in_data,
  // Coefficients
  input wire logic signed [DATA_W-1:0] offset_coeff,
  input wire logic [DATA_W-1:0] gain_coeff,
  // Corrected word
  output logic out_valid,
  output logic signed [DATA_W-1:0] out_data,
  output logic out_clipped
);
  localparam int PW = 2 * DATA_W + 2;
  localparam logic signed [PW-1:0] MAXV = {{(DATA_W + 3){1'b0}}, {(DATA_W - 1){1'b1}}};
  localparam logic signed [PW-1:0] MINV = {{(DATA_W + 3){1'b1}}, {(DATA_W - 1){1'b0}}};

  logic signed [DATA_W:0] diff;
  logic signed [PW-1:0] prod;
  logic signed [PW-1:0] scaled;
  logic next_out_valid;
  logic signed [DATA_W-1:0] next_out_data;
  logic next_out_clipped;

  always_comb begin
    // Offset first, then gain
    diff = {in_data[DATA_W-1], in_data} - {offset_coeff[DATA_W-1], offset_coeff};
    prod = diff * $signed({1'b0, gain_coeff});
    scaled = prod >>> GAIN_FRAC;
    next_out_valid = in_valid;
    next_out_clipped = 1'b0;
    // Clip rather than wrap on overflow
    if (scaled > MAXV) begin
      next_out_data = MAXV[DATA_W-1:0];
      next_out_clipped = in_valid;
    end else if (scaled < MINV) begin
      next_out_data = MINV[DATA_W-1:0];
      next_out_clipped = in_valid;
    end else begin
      next_out_data = scaled[DATA_W-1:0];
    end
    if (!in_valid) begin
      next_out_data = out_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_valid <= 1'b0;
      out_data <= '0;
      out_clipped <= 1'b0;
    end else begin
      out_valid <= next_out_valid;
      out_data <= next_out_data;
      out_clipped <= next_out_clipped;
    end
  end
endmodule // agoc_correct
`default_nettype wire

/* File: hw/agoc_top.sv */
// Gain and offset correction with precision averaging and self-calibration
//
// Contract
// - Offset is subtracted from the raw result first, then scaled by the gain.
// - Factory gain and offset coefficients are held and can be applied.
// - Self-calibration measures a reference and a zero input and derives both coefficients.
// - Setting the averaging enable puts the path into precision mode.
// - Precision mode averages the difference of two swapped conversions.
// - Precision mode delivers results at half the plain output rate.
`timescale 1ns/1ps
`default_nettype none
`include "agoc_defs.svh"
module agoc_top #(
  parameter int DATA_W = `AGOC_DATA_W,
  parameter int GAIN_FRAC = `AGOC_GAIN_FRAC,
  parameter logic [3:0] SETTLE_SAMPLES = `AGOC_SETTLE_SAMPLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Raw conversions from the modulator filter
  input wire logic raw_valid,
  input wire logic signed [DATA_W-1:0] raw_data,
  // Mode and coefficient controls
  input wire logic offset_averaging_enable,
  input wire agoc_pkg::agoc_coeff_sel_type coeff_select,
  input wire logic signed [DATA_W-1:0] offset_correction_coeff,
  input wire logic [DATA_W-1:0] gain_correction_coeff,
  // Self-calibration control
  input wire logic cal_start,
  input wire logic cal_use_low_ref,
  output logic cal_busy,
  output logic cal_done,
  output logic cal_error,
  output logic signed [DATA_W-1:0] self_offset_coeff,
  output logic [DATA_W-1:0] self_gain_coeff,
  // Front-end steering
  output agoc_pkg::agoc_source_type cal_source,
  output logic input_swap,
  // Corrected results
  output logic result_valid,
  output logic signed [DATA_W-1:0] result_data,
  output logic result_clipped
);
  localparam int NB = DATA_W + GAIN_FRAC;
  localparam int CW = $clog2(NB + 1);
  localparam logic [DATA_W-1:0] UNITY = DATA_W'(`AGOC_GAIN_UNITY);
  localparam logic [DATA_W-1:0] ZERO = DATA_W'(`AGOC_OFFSET_ZERO);
  localparam logic [DATA_W-1:0] REF_HIGH = DATA_W'(`AGOC_REF_HIGH_CODE);
  localparam logic [DATA_W-1:0] REF_LOW = DATA_W'(`AGOC_REF_LOW_CODE);
  // Factory set is fixed at build time and survives any reset
  localparam logic [DATA_W-1:0] FACT_OFFSET = DATA_W'(`AGOC_FACTORY_OFFSET);
  localparam logic [DATA_W-1:0] FACT_GAIN = DATA_W'(`AGOC_FACTORY_GAIN);

  // Divider and saturation bounds assume these ranges
  if (DATA_W < 8 || DATA_W > 31 || GAIN_FRAC < 1 || GAIN_FRAC >= DATA_W) begin : g_bad_width
    $error("agoc_top: unsupported DATA_W or GAIN_FRAC");
  end

  // ----------------------------------------
  // Precision averaging
  // ----------------------------------------
  logic phase;
  logic signed [DATA_W-1:0] first_sample;
  logic pre_valid;
  logic signed [DATA_W-1:0] pre_data;
  logic next_phase;
  logic signed [DATA_W-1:0] next_first_sample;
  logic next_pre_valid;
  logic signed [DATA_W-1:0] next_pre_data;
  logic signed [DATA_W:0] pair_diff;

  always_comb begin
    next_phase = phase;
    next_first_sample = first_sample;
    next_pre_valid = 1'b0;
    next_pre_data = pre_data;
    pair_diff = {first_sample[DATA_W-1], first_sample} - {raw_data[DATA_W-1], raw_data};
    if (!offset_averaging_enable) begin
      // Leaving precision mode drops any half pair
      next_phase = 1'b0;
      if (raw_valid) begin
        next_pre_valid = 1'b1;
        next_pre_data = raw_data;
      end
    end else if (raw_valid) begin
      if (!phase) begin
        next_first_sample = raw_data;
        next_phase = 1'b1;
      end else begin
        // Second conversion runs swapped, so offset cancels in the difference
        next_pre_data = pair_diff[DATA_W:1];
        next_pre_valid = 1'b1;
        next_phase = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phase <= 1'b0;
      first_sample <= '0;
      pre_valid <= 1'b0;
      pre_data <= '0;
    end else begin
      phase <= next_phase;
      first_sample <= next_first_sample;
      pre_valid <= next_pre_valid;
      pre_data <= next_pre_data;
    end
  end

  assign input_swap = phase;

  // ----------------------------------------
  // Self-calibration sequence and divider
  // ----------------------------------------
  agoc_pkg::agoc_cal_state_type state;
  agoc_pkg::agoc_cal_state_type next_state;
  logic [3:0] skip;
  logic [3:0] next_skip;
  logic use_low;
  logic next_use_low;
  logic signed [DATA_W-1:0] zero_meas;
  logic signed [DATA_W-1:0] next_zero_meas;
  logic [NB-1:0] quot;
  logic [NB-1:0] next_quot;
  logic [DATA_W:0] rem;
  logic [DATA_W:0] next_rem;
  logic [DATA_W-1:0] den;
  logic [DATA_W-1:0] next_den;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic signed [DATA_W-1:0] next_self_offset;
  logic [DATA_W-1:0] next_self_gain;
  logic next_cal_done;
  logic next_cal_error;
  logic signed [DATA_W:0] span;
  logic [DATA_W:0] rem_shift;

  always_comb begin
    next_state = state;
    next_skip = skip;
    next_use_low = use_low;
    next_zero_meas = zero_meas;
    next_quot = quot;
    next_rem = rem;
    next_den = den;
    next_cnt = cnt;
    next_self_offset = self_offset_coeff;
    next_self_gain = self_gain_coeff;
    next_cal_done = 1'b0;
    next_cal_error = cal_error;
    span = {pre_data[DATA_W-1], pre_data} - {zero_meas[DATA_W-1], zero_meas};
    rem_shift = {rem[DATA_W-1:0], quot[NB-1]};
    case (state)
      agoc_pkg::CAL_IDLE: begin
        if (cal_start) begin
          next_state = agoc_pkg::CAL_ZERO;
          next_use_low = cal_use_low_ref;
          next_skip = SETTLE_SAMPLES;
          next_cal_error = 1'b0;
        end
      end
      agoc_pkg::CAL_ZERO: begin
        if (pre_valid) begin
          // Samples in flight from the previous source are thrown away
          if (skip != 4'h0) begin
            next_skip = skip - 4'h1;
          end else begin
            next_zero_meas = pre_data;
            next_skip = SETTLE_SAMPLES;
            next_state = agoc_pkg::CAL_REF;
          end
        end
      end
      agoc_pkg::CAL_REF: begin
        if (pre_valid) begin
          if (skip != 4'h0) begin
            next_skip = skip - 4'h1;
          end else if (span[DATA_W] || span == '0) begin
            next_cal_error = 1'b1;
            next_cal_done = 1'b1;
            next_state = agoc_pkg::CAL_IDLE;
          end else begin
            // Gain is stored reference over measured span
            next_den = span[DATA_W-1:0];
            next_quot = {use_low ? REF_LOW : REF_HIGH, {GAIN_FRAC{1'b0}}};
            next_rem = '0;
            next_cnt = CW'(NB);
            next_state = agoc_pkg::CAL_DIV;
          end
        end
      end
      agoc_pkg::CAL_DIV: begin
        // One quotient bit per cycle keeps the divider small
        if (cnt != '0) begin
          next_cnt = cnt - CW'(1);
          if (rem_shift >= {1'b0, den}) begin
            next_rem = rem_shift - {1'b0, den};
            next_quot = {quot[NB-2:0], 1'b1};
          end else begin
            next_rem = rem_shift;
            next_quot = {quot[NB-2:0], 1'b0};
          end
        end else begin
          next_self_offset = zero_meas;
          if (quot[NB-1:DATA_W] != '0) begin
            next_self_gain = '1;
          end else begin
            next_self_gain = quot[DATA_W-1:0];
          end
          next_cal_done = 1'b1;
          next_state = agoc_pkg::CAL_IDLE;
        end
      end
      default: begin
        next_state = agoc_pkg::CAL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= agoc_pkg::CAL_IDLE;
      skip <= 4'h0;
      use_low <= 1'b0;
      zero_meas <= '0;
      quot <= '0;
      rem <= '0;
      den <= '0;
      cnt <= '0;
      self_offset_coeff <= ZERO;
      self_gain_coeff <= UNITY;
      cal_done <= 1'b0;
      cal_error <= 1'b0;
    end else begin
      state <= next_state;
      skip <= next_skip;
      use_low <= next_use_low;
      zero_meas <= next_zero_meas;
      quot <= next_quot;
      rem <= next_rem;
      den <= next_den;
      cnt <= next_cnt;
      self_offset_coeff <= next_self_offset;
      self_gain_coeff <= next_self_gain;
      cal_done <= next_cal_done;
      cal_error <= next_cal_error;
    end
  end

  assign cal_busy = (state != agoc_pkg::CAL_IDLE);

  always_comb begin
    case (state)
      agoc_pkg::CAL_ZERO: cal_source = agoc_pkg::SRC_ZERO;
      agoc_pkg::CAL_REF: cal_source = use_low ? agoc_pkg::SRC_REF_LOW : agoc_pkg::SRC_REF_HIGH;
      default: cal_source = agoc_pkg::SRC_SIGNAL;
    endcase
  end

  // ----------------------------------------
  // Coefficient selection and correction
  // ----------------------------------------
  logic signed [DATA_W-1:0] use_offset;
  logic [DATA_W-1:0] use_gain;

  always_comb begin
    case (coeff_select)
      agoc_pkg::COEFF_USER: begin
        use_offset = offset_correction_coeff;
        use_gain = gain_correction_coeff;
      end
      agoc_pkg::COEFF_SELF: begin
        use_offset = self_offset_coeff;
        use_gain = self_gain_coeff;
      end
      default: begin
        use_offset = FACT_OFFSET;
        use_gain = FACT_GAIN;
      end
    endcase
  end

  agoc_correct #(
    .DATA_W(DATA_W),
    .GAIN_FRAC(GAIN_FRAC)
  ) u_correct (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(pre_valid),
    .in_data(pre_data),
    .offset_coeff(use_offset),
    .gain_coeff(use_gain),
    .out_valid(result_valid),
    .out_data(result_data),
    .out_clipped(result_clipped)
  );
endmodule // agoc_top
`default_nettype wire

/* File: inc/agoc_defs.svh */
// Constants for the gain and offset correction block
`ifndef AGOC_DEFS_SVH
`define AGOC_DEFS_SVH
// ----------------------------------------
// Word layout
// ----------------------------------------
`define AGOC_DATA_W 24
`define AGOC_GAIN_FRAC 22
// ----------------------------------------
// Reset and stored values
// ----------------------------------------
`define AGOC_GAIN_UNITY 24'h40_0000
`define AGOC_OFFSET_ZERO 24'h00_0000
`define AGOC_FACTORY_OFFSET 24'h00_0000
`define AGOC_FACTORY_GAIN 24'h40_0000
`define AGOC_REF_HIGH_CODE 24'h70_0000
`define AGOC_REF_LOW_CODE 24'h0A_0000
// ----------------------------------------
// Timing counts
// ----------------------------------------
`define AGOC_SETTLE_SAMPLES 4'h1
`endif

/* File: inc/agoc_pkg.sv */
// Types shared by the gain and offset correction block
package agoc_pkg;
  // Coefficient set applied to the data path
  typedef enum logic [1:0] {
    COEFF_FACTORY,
    COEFF_USER,
    COEFF_SELF
  } agoc_coeff_sel_type;
  // Source routed to the converter input
  typedef enum logic [1:0] {
    SRC_SIGNAL,
    SRC_ZERO,
    SRC_REF_HIGH,
    SRC_REF_LOW
  } agoc_source_type;
  // Self-calibration sequence
  typedef enum logic [2:0] {
    CAL_IDLE,
    CAL_ZERO,
    CAL_REF,
    CAL_DIV
  } agoc_cal_state_type;
endpackage

/* File: verif/adc_gain_offset_calibration_tb.sv */
// Self-checking bench for the correction block
`timescale 1ns/1ps
`default_nettype none
`define CHECK_EQ(act, want) begin num_checks++; if ((act) !== (want)) begin failures++; \
  $display("ERROR %0t got %h expected %h", $time, act, want); end end
module adc_gain_offset_calibration_tb;
  typedef struct {
    agoc_pkg::agoc_coeff_sel_type sel;
    logic signed [23:0] raw;
    logic signed [23:0] off;
    logic [23:0] gain;
    logic signed [23:0] want;
    logic clip;
  } agoc_row_type;
  localparam logic signed [23:0] OFS = 24'h00_0300;
  logic clk = 0, sys_rst = 1, b_valid = 0, use_model = 0, avg_en = 0, cal_start = 0, low_ref = 0;
  logic signed [23:0] b_data = '0, off = '0, signal_in = '0, raw_data, result_data, s_off, m_data;
  logic [23:0] gain = 24'h40_0000, s_gain;
  logic raw_valid, m_valid, cal_busy, cal_done, cal_error, input_swap, result_valid, result_clipped;
  agoc_pkg::agoc_coeff_sel_type sel = agoc_pkg::COEFF_USER;
  agoc_pkg::agoc_source_type cal_source;
  int failures = 0, num_checks = 0, n;
  // Zero and unity first, order and saturation cases after
  agoc_row_type rows [7] = '{
    '{agoc_pkg::COEFF_USER, 24'h10_0000, 24'h00_0000, 24'h40_0000, 24'h10_0000, 0},
    '{agoc_pkg::COEFF_USER, 24'h10_0000, 24'h00_1000, 24'h20_0000, 24'h07_F800, 0},
    '{agoc_pkg::COEFF_USER, 24'h00_0100, 24'h00_0080, 24'h80_0000, 24'h00_0100, 0},
    '{agoc_pkg::COEFF_USER, 24'hFF_FFF0, 24'hFF_FFF0, 24'h60_0000, 24'h00_0000, 0},
    '{agoc_pkg::COEFF_USER, 24'h70_0000, 24'h00_0000, 24'h80_0000, 24'h7F_FFFF, 1},
    '{agoc_pkg::COEFF_USER, 24'h80_0000, 24'h00_0010, 24'h40_0000, 24'h80_0000, 1},
    '{agoc_pkg::COEFF_FACTORY, 24'h12_3456, 24'h00_1000, 24'h20_0000, 24'h12_3456, 0}
  };
  assign raw_valid = use_model ? m_valid : b_valid;
  assign raw_data = use_model ? m_data : b_data;
  always #5 clk = ~clk;
  agoc_top DUT (.clk(clk), .sys_rst(sys_rst), .raw_valid(raw_valid), .raw_data(raw_data),
    .offset_averaging_enable(avg_en), .coeff_select(sel), .offset_correction_coeff(off),
    .gain_correction_coeff(gain), .cal_start(cal_start), .cal_use_low_ref(low_ref),
    .cal_busy(cal_busy), .cal_done(cal_done), .cal_error(cal_error), .self_offset_coeff(s_off),
    .self_gain_coeff(s_gain), .cal_source(cal_source), .input_swap(input_swap),
    .result_valid(result_valid), .result_data(result_data), .result_clipped(result_clipped));
  agoc_front_model #(.OFS(OFS), .PERIOD(4)) u_front (.clk(clk), .run(use_model),
    .signal_in(signal_in), .cal_source(cal_source), .input_swap(input_swap),
    .raw_valid(m_valid), .raw_data(m_data));
  task automatic pulse_raw(input logic signed [23:0] d);
    @(posedge clk);
    b_valid <= 1'b1;
    b_data <= d;
    @(posedge clk);
    b_valid <= 1'b0;
    b_data <= ~d;
  endtask
  task automatic next_result;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (result_valid !== 1'b1 && n < 50);
    `CHECK_EQ(result_valid, 1'b1)
  endtask
  task automatic wait_cal_done;
    n = 0;
    while (cal_done !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  // Host two-point procedure: zero and unity, two readings, reciprocal gain, then offset
  task automatic host_two_point(input logic signed [23:0] x1, input logic signed [23:0] x2);
    logic signed [23:0] y1;
    logic signed [23:0] y2;
    longint ga_num;
    longint ga_den;
    @(posedge clk);
    sel <= agoc_pkg::COEFF_USER;
    off <= 24'h00_0000;
    gain <= 24'h40_0000;
    signal_in <= x1;
    next_result;
    next_result;
    y1 = result_data;
    `CHECK_EQ(y1, x1 - (x1 >>> 2) + OFS)
    @(posedge clk);
    signal_in <= x2;
    next_result;
    next_result;
    y2 = result_data;
    ga_num = longint'(y2) - longint'(y1);
    ga_den = longint'(x2) - longint'(x1);
    @(posedge clk);
    gain <= 24'((ga_den <<< 22) / ga_num);
    off <= 24'(longint'(y1) - (ga_num * longint'(x1)) / ga_den);
    signal_in <= 24'h10_0000;
    next_result;
    next_result;
    `CHECK_EQ(result_data, 24'h0F_FFFF)
  endtask
  task automatic count_results(output int c);
    c = 0;
    repeat (80) begin
      @(posedge clk);
      #1;
      if (result_valid === 1'b1) c++;
    end
  endtask
  task automatic complete_run;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    `CHECK_EQ(s_gain, 24'h40_0000)
    `CHECK_EQ(cal_busy, 1'b0)
    foreach (rows[i]) begin
      @(posedge clk);
      sel <= rows[i].sel;
      off <= rows[i].off;
      gain <= rows[i].gain;
      pulse_raw(rows[i].raw);
      @(posedge clk);
      #1;
      `CHECK_EQ(result_valid, 1'b1)
      `CHECK_EQ(result_data, rows[i].want)
      `CHECK_EQ(result_clipped, rows[i].clip)
    end
    // Both references give the same slope through the 3/4 front end
    for (int r = 0; r < 2; r++) begin
      @(posedge clk);
      use_model <= 1'b1;
      low_ref <= r[0];
      cal_start <= 1'b1;
      @(posedge clk);
      cal_start <= 1'b0;
      wait_cal_done;
      `CHECK_EQ(cal_done, 1'b1)
      `CHECK_EQ(cal_error, 1'b0)
      `CHECK_EQ(s_off, OFS)
      `CHECK_EQ(s_gain, 24'h55_5555)
    end
    // Equal zero and reference readings must fail and keep the old set
    @(posedge clk);
    use_model <= 1'b0;
    cal_start <= 1'b1;
    @(posedge clk);
    cal_start <= 1'b0;
    repeat (4) pulse_raw(24'h10_0000);
    wait_cal_done;
    `CHECK_EQ(cal_done, 1'b1)
    `CHECK_EQ(cal_error, 1'b1)
    `CHECK_EQ(s_gain, 24'h55_5555)
    @(posedge clk);
    use_model <= 1'b1;
    sel <= agoc_pkg::COEFF_SELF;
    signal_in <= 24'h10_0000;
    next_result;
    next_result;
    `CHECK_EQ(result_data, 24'h0F_FFFF)
    // Voltage points near both full scales, then resistance at 80 % and a short
    host_two_point(24'h7F_0000, 24'h81_0000);
    host_two_point(24'h66_6666, 24'h00_0000);
    @(posedge clk);
    sel <= agoc_pkg::COEFF_USER;
    gain <= 24'h40_0000;
    off <= '0;
    count_results(n);
    `CHECK_EQ(n, 20)
    `CHECK_EQ(result_data, 24'h0C_0300)
    @(posedge clk);
    avg_en <= 1'b1;
    repeat (16) @(posedge clk);
    count_results(n);
    `CHECK_EQ(n, 10)
    `CHECK_EQ(result_data, 24'h0C_0000)
    // Reset in mid-run drops the self set and any half pair
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    `CHECK_EQ(s_gain, 24'h40_0000)
    `CHECK_EQ(s_off, 24'h00_0000)
    `CHECK_EQ(cal_error, 1'b0)
    `CHECK_EQ(result_valid, 1'b0)
    `CHECK_EQ(input_swap, 1'b0)
    count_results(n);
    `CHECK_EQ(n, 10)
    complete_run;
  end
  // Run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    complete_run;
  end
endmodule // adc_gain_offset_calibration_tb
bind agoc_top agoc_properties #(.DATA_W(DATA_W)) u_props (.clk(clk), .sys_rst(sys_rst),
  .raw_valid(raw_valid), .offset_averaging_enable(offset_averaging_enable),
  .input_swap(input_swap), .result_valid(result_valid), .result_data(result_data),
  .result_clipped(result_clipped), .cal_start(cal_start), .cal_busy(cal_busy),
  .cal_done(cal_done), .cal_source(cal_source));
`default_nettype wire

/* File: verif/agoc_front_model.sv */
// Front end model: source steering, gain of 3/4 and a fixed offset
`timescale 1ns/1ps
`default_nettype none
`include "agoc_defs.svh"
module agoc_front_model #(
  parameter logic signed [23:0] OFS = 24'h00_0000,
  parameter int PERIOD = 4
) (
  // Clock and control
  input wire logic clk,
  input wire logic run,
  input wire logic signed [23:0] signal_in,
  input wire agoc_pkg::agoc_source_type cal_source,
  input wire logic input_swap,
  // Raw conversions
  output logic raw_valid,
  output logic signed [23:0] raw_data
);
  int cnt = 0;
  logic signed [23:0] x;
  logic signed [23:0] y;
  initial raw_valid = 1'b0;
  initial raw_data = '0;
  always_comb begin
    case (cal_source)
      agoc_pkg::SRC_ZERO: x = '0;
      agoc_pkg::SRC_REF_HIGH: x = `AGOC_REF_HIGH_CODE;
      agoc_pkg::SRC_REF_LOW: x = `AGOC_REF_LOW_CODE;
      default: x = signal_in;
    endcase
    y = x - (x >>> 2);
  end
  // Swap flips the signal only, so the offset cancels in a pair
  always @(posedge clk) begin
    cnt <= (cnt + 1) % PERIOD;
    raw_valid <= run && cnt == 0;
    raw_data <= (run && cnt == 0) ? (input_swap ? -y : y) + OFS : ~raw_data;
  end
endmodule // agoc_front_model
`default_nettype wire

/* File: verif/agoc_properties.sv */
// Port checker for the correction block
`timescale 1ns/1ps
`default_nettype none
module agoc_properties #(
  parameter int DATA_W = 24
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Data path
  input wire logic raw_valid,
  input wire logic offset_averaging_enable,
  input wire logic input_swap,
  input wire logic result_valid,
  input wire logic signed [DATA_W-1:0] result_data,
  input wire logic result_clipped,
  // Self-calibration
  input wire logic cal_start,
  input wire logic cal_busy,
  input wire logic cal_done,
  input wire agoc_pkg::agoc_source_type cal_source
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  sequence s_answer;
    ##2 result_valid;
  endsequence
  sequence s_first;
    raw_valid && offset_averaging_enable && !input_swap;
  endsequence
  a_plain_latency: assert property (raw_valid && !offset_averaging_enable |-> s_answer)
    else $error("plain result missing");
  a_result_cause: assert property (result_valid |-> $past(raw_valid, 2))
    else $error("result without conversion");
  a_first_silent: assert property (s_first |-> ##2 !result_valid)
    else $error("first of pair produced output");
  a_swap_follows: assert property (s_first |=> input_swap)
    else $error("no swap after first sample");
  a_pair_answer: assert property (raw_valid && offset_averaging_enable && input_swap |-> s_answer)
    else $error("pair result missing");
  a_clip_value: assert property (result_clipped |-> result_valid && (result_data == {1'b0, {(DATA_W-1){1'b1}}} || result_data == {1'b1, {(DATA_W-1){1'b0}}}))
    else $error("clip flag with unsaturated word");
  a_cal_begin: assert property (cal_start && !cal_busy |=> cal_busy && cal_source == agoc_pkg::SRC_ZERO)
    else $error("calibration did not start on zero");
  a_done_ends: assert property (cal_done |-> !cal_busy && $past(cal_busy))
    else $error("done without busy end");
  a_idle_source: assert property (!cal_busy |-> cal_source == agoc_pkg::SRC_SIGNAL)
    else $error("source steered while idle");
endmodule // agoc_properties
`default_nettype wire
